// ==== core/xbus_sel_cfg.svh ====
// Offsets, field positions, reset values and windows of the select decoder
`ifndef XBUS_SEL_CFG_SVH
`define XBUS_SEL_CFG_SVH

// Register byte offsets on the AXI4-Lite slave
`define OFS_PERIPH_SEL   8'h00
`define OFS_SYS_CONFIG   8'h04
`define OFS_STATUS       8'h08

// Fields of the peripheral select register
`define FLD_FIRST_CAN    0
`define FLD_SECOND_CAN   1
`define FLD_EXT_RAM      2
`define FLD_GROUP        3
`define FLD_PWM          4
`define SEL_WIDTH        5
`define SEL_RESET        5'h05

// Field of the system configuration register
`define FLD_GLOBAL_EN    0

// Fields of the status register
`define FLD_ST_LOCKED    0
`define FLD_ST_CAN1_GPIO 1
`define FLD_ST_CAN2_GPIO 2

// Extension windows, compared on address bits 23:8
`define WIN_PWM          16'h00ec
`define WIN_GAP          16'h00ed
`define WIN_SECOND_CAN   16'h00ee
`define WIN_FIRST_CAN    16'h00ef

// AXI responses
`define RESP_OKAY        2'b00
`define RESP_DECERR      2'b11

`endif

// ==== core/xbus_sel_pkg.sv ====
// Types shared by the extension-bus select decoder
package xbus_sel_pkg;

   // Where a CPU access to the extension bus is steered
   typedef enum logic [2:0] {
      RT_EXTERNAL,
      RT_FIRST_CAN,
      RT_SECOND_CAN,
      RT_EXT_RAM,
      RT_GROUP,
      RT_PWM,
      RT_BLOCKED
   } route_t;

endpackage

// ==== core/xbus_peripheral_select_decode.sv ====
// Extension-bus peripheral select register and access steering
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "xbus_sel_cfg.svh"

module xbus_peripheral_select_decode #(
   parameter int ADDR_W       = 8,
   parameter int EXT_RAM_BASE = 24'h00c000,
   parameter int EXT_RAM_SIZE = 16384,
   parameter int GRP_BASE     = 24'h00e000,
   parameter int GRP_SIZE     = 1024
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 ce,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // CPU extension-bus access to steer
   input  wire logic                 cpu_req_valid,
   input  wire logic [23:0]          cpu_req_addr,
   output logic                      route_valid,
   output xbus_sel_pkg::route_t      route,
   // Selection state seen by the rest of the chip
   output logic [`SEL_WIDTH-1:0]     periph_enable,
   output logic                      global_xbus_enable,
   output logic                      first_can_pins_gpio,
   output logic                      second_can_pins_gpio
);
   import xbus_sel_pkg::*;

   // Windows are matched by masking the address, so each must be a power
   // of two in size, aligned to that size and inside the 24-bit space
   localparam bit RAM_OK = EXT_RAM_SIZE > 0 && EXT_RAM_SIZE <= 24'h800000
      && (EXT_RAM_SIZE & (EXT_RAM_SIZE - 1)) == 0
      && EXT_RAM_BASE >= 0 && EXT_RAM_BASE <= 24'hffffff
      && (EXT_RAM_BASE & (EXT_RAM_SIZE - 1)) == 0;
   localparam bit GRP_OK = GRP_SIZE > 0 && GRP_SIZE <= 24'h800000
      && (GRP_SIZE & (GRP_SIZE - 1)) == 0
      && GRP_BASE >= 0 && GRP_BASE <= 24'hffffff
      && (GRP_BASE & (GRP_SIZE - 1)) == 0;

   // Elaboration checks: refuse what the decoder cannot serve
   if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk_addr_w
      $error("ADDR_W must lie in 4..32");
   end
   if (!RAM_OK) begin : g_chk_ram
      $error("Extension RAM window must be an aligned power of two");
   end
   if (!GRP_OK) begin : g_chk_grp
      $error("Group window must be an aligned power of two");
   end

   // 24-bit base and mask of each window
   localparam logic [23:0] RAM_B = EXT_RAM_BASE[23:0];
   localparam logic [23:0] RAM_M = ~(EXT_RAM_SIZE[23:0] - 24'h000001);
   localparam logic [23:0] GRP_B = GRP_BASE[23:0];
   localparam logic [23:0] GRP_M = ~(GRP_SIZE[23:0] - 24'h000001);

   // Register state
   logic [`SEL_WIDTH-1:0] sel_q, sel_d;
   logic                  gen_q, gen_d;
   // AXI write channel state
   logic                  aw_full_q, aw_full_d;
   logic                  w_full_q, w_full_d;
   logic [ADDR_W-1:0]     waddr_q, waddr_d;
   logic [31:0]           wdata_q, wdata_d;
   logic [3:0]            wstrb_q, wstrb_d;
   logic                  awready_q, awready_d;
   logic                  wready_q, wready_d;
   logic                  bvalid_q, bvalid_d;
   logic [1:0]            bresp_q, bresp_d;
   // AXI read channel state
   logic                  arready_q, arready_d;
   logic                  rvalid_q, rvalid_d;
   logic [31:0]           rdata_q, rdata_d;
   logic [1:0]            rresp_q, rresp_d;
   // Steering state
   logic                  rvld_q, rvld_d;
   route_t                route_q, route_d;
   logic                  gpio1_q, gpio1_d;
   logic                  gpio2_q, gpio2_d;

   logic                  do_write;
   logic [ADDR_W-1:0]     a_sel, a_sys, a_sta;

   assign a_sel = ADDR_W'(`OFS_PERIPH_SEL);
   assign a_sys = ADDR_W'(`OFS_SYS_CONFIG);
   assign a_sta = ADDR_W'(`OFS_STATUS);

   // Write commits once both address and data are held and no answer waits
   assign do_write = aw_full_q && w_full_q && !bvalid_q;

   // Write channels: address and data taken in either order
   always_comb begin
      aw_full_d = aw_full_q;
      w_full_d  = w_full_q;
      waddr_d   = waddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      sel_d     = sel_q;
      gen_d     = gen_q;
      if (s_axi_awvalid && awready_q) begin
         aw_full_d = 1'b1;
         waddr_d   = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_full_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
      end
      // Response is held until the master takes it
      if (bvalid_q && s_axi_bready)
         bvalid_d = 1'b0;
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = `RESP_OKAY;
         if (waddr_q == a_sel) begin
            // Once the global enable is set the selection is frozen
            if (!gen_q && wstrb_q[0])
               sel_d = wdata_q[`SEL_WIDTH-1:0];
         end else if (waddr_q == a_sys) begin
            // Set-only: clearing would reopen a frozen selection
            if (wstrb_q[0] && wdata_q[`FLD_GLOBAL_EN])
               gen_d = 1'b1;
         end else if (waddr_q != a_sta) begin
            bresp_d = `RESP_DECERR;
         end
      end
      // Ready follows the next holding state so it drops at capture
      awready_d = !aw_full_d;
      wready_d  = !w_full_d;
   end

   // Write channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         waddr_q   <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
         sel_q     <= `SEL_RESET;
         gen_q     <= 1'b0;
      end else if (ce) begin
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         waddr_q   <= waddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         sel_q     <= sel_d;
         gen_q     <= gen_d;
      end
   end

   // Read channel: one read at a time, answer the cycle after capture
   always_comb begin
      arready_d = arready_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      // Ready comes up on the first enabled edge after reset
      if (!rvalid_q && !arready_q)
         arready_d = 1'b1;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d  = 1'b0;
         arready_d = 1'b1;
      end
      // Capture; unmapped offsets read zero with a decode error
      if (s_axi_arvalid && arready_q) begin
         arready_d = 1'b0;
         rvalid_d  = 1'b1;
         rresp_d   = `RESP_OKAY;
         rdata_d   = 32'h00000000;
         if (s_axi_araddr == a_sel)
            rdata_d[`SEL_WIDTH-1:0] = sel_q;
         else if (s_axi_araddr == a_sys)
            rdata_d[`FLD_GLOBAL_EN] = gen_q;
         else if (s_axi_araddr == a_sta) begin
            // Status gathers lock and pin release, all read-only
            rdata_d[`FLD_ST_LOCKED]    = gen_q;
            rdata_d[`FLD_ST_CAN1_GPIO] = gpio1_q;
            rdata_d[`FLD_ST_CAN2_GPIO] = gpio2_q;
         end else
            rresp_d = `RESP_DECERR;
      end
   end

   // Read channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= `RESP_OKAY;
      end else if (ce) begin
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   // Steering of one CPU access, answered one cycle later
   always_comb begin
      logic c1, c2, pw, any;
      logic [15:0] pg;
      c1  = sel_q[`FLD_FIRST_CAN];
      c2  = sel_q[`FLD_SECOND_CAN];
      pw  = sel_q[`FLD_PWM];
      any = c1 | c2 | pw;
      pg  = cpu_req_addr[23:8];
      // Pulse follows every request on an enabled edge; route holds until the next one
      rvld_d  = cpu_req_valid;
      route_d = route_q;
      if (cpu_req_valid) begin
         // With every CAN and PWM unit off, the range is plain memory
         if (!any && pg >= `WIN_PWM && pg <= `WIN_FIRST_CAN)
            route_d = RT_EXTERNAL;
         else if (pg == `WIN_FIRST_CAN)
            route_d = c1 ? RT_FIRST_CAN : RT_BLOCKED;
         else if (pg == `WIN_SECOND_CAN)
            route_d = c2 ? RT_SECOND_CAN : RT_BLOCKED;
         else if (pg == `WIN_PWM)
            route_d = pw ? RT_PWM : RT_BLOCKED;
         // No unit sits in the gap page; it opens only with the range
         else if (pg == `WIN_GAP)
            route_d = RT_BLOCKED;
         // The group window may lie inside the RAM window, so it is tried
         // first; the other order would shadow the group for good
         else if ((cpu_req_addr & GRP_M) == GRP_B)
            route_d = sel_q[`FLD_GROUP] ? RT_GROUP
                                        : RT_EXTERNAL;
         else if ((cpu_req_addr & RAM_M) == RAM_B)
            route_d = sel_q[`FLD_EXT_RAM] ? RT_EXT_RAM
                                          : RT_EXTERNAL;
         else
            route_d = RT_EXTERNAL;
      end
      // Pins of a disabled controller are handed back to the port
      gpio1_d = !c1;
      gpio2_d = !c2;
   end

   // Steering registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvld_q  <= 1'b0;
         route_q <= RT_EXTERNAL;
         // Pins match the reset selection: first CAN on, second off
         gpio1_q <= 1'b0;
         gpio2_q <= 1'b1;
      end else if (ce) begin
         rvld_q  <= rvld_d;
         route_q <= route_d;
         gpio1_q <= gpio1_d;
         gpio2_q <= gpio2_d;
      end
   end

   // Outputs straight from flip-flops
   assign s_axi_awready        = awready_q;
   assign s_axi_wready         = wready_q;
   assign s_axi_bvalid         = bvalid_q;
   assign s_axi_bresp          = bresp_q;
   assign s_axi_arready        = arready_q;
   assign s_axi_rvalid         = rvalid_q;
   assign s_axi_rdata          = rdata_q;
   assign s_axi_rresp          = rresp_q;
   assign route_valid          = rvld_q;
   assign route                = route_q;
   assign periph_enable        = sel_q;
   assign global_xbus_enable   = gen_q;
   assign first_can_pins_gpio  = gpio1_q;
   assign second_can_pins_gpio = gpio2_q;

endmodule // xbus_peripheral_select_decode

// ==== tb/cpu_access_model.sv ====
// CPU-side requester that issues extension-bus accesses
`timescale 1ns/1ps
module cpu_access_model (
   input  wire logic        aclk,
   output logic             req_valid,
   output logic [23:0]      req_addr
);
   initial begin
      req_valid = 1'b0;
      req_addr  = 24'h000000;
   end

   // One-cycle request; the address is inverted once released so that a
   // decoder reading it outside the pulse sees no stale page
   task automatic access(input logic [23:0] a);
      req_valid <= 1'b1;
      req_addr  <= a;
      @(posedge aclk);
      req_valid <= 1'b0;
      req_addr  <= ~a;
   endtask
endmodule // cpu_access_model

// ==== tb/xbus_sel_monitor.sv ====
// Port-level assertions for the extension-bus select decoder
`timescale 1ns/1ps
`include "xbus_sel_cfg.svh"
module xbus_sel_monitor
   import xbus_sel_pkg::*;
(
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  ce,
   input wire logic                  cpu_req_valid,
   input wire logic [23:0]           cpu_req_addr,
   input wire logic                  route_valid,
   input wire xbus_sel_pkg::route_t  route,
   input wire logic [`SEL_WIDTH-1:0] periph_enable,
   input wire logic                  global_xbus_enable,
   input wire logic                  first_can_pins_gpio,
   input wire logic                  second_can_pins_gpio
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Page owner wins; otherwise blocked unless all three units are off
   function automatic route_t page(input logic on, input logic others,
                                   input route_t unit);
      return on ? unit : others ? RT_BLOCKED : RT_EXTERNAL;
   endfunction

   AST_RESET_SEL: assert property ($rose(aresetn) |->
      periph_enable == `SEL_RESET && !global_xbus_enable)
      else $error("select register not at reset value");
   AST_ROUTE_PULSE: assert property (
      cpu_req_valid && ce |=> route_valid)
      else $error("access not steered one cycle later");
   AST_NO_ROUTE: assert property (
      !cpu_req_valid && ce |=> !route_valid)
      else $error("steering pulse without an access");
   AST_FIRST_CAN_PAGE: assert property (
      cpu_req_valid && ce && cpu_req_addr[23:8] == `WIN_FIRST_CAN |=>
      route == page($past(periph_enable[0]),
         $past(periph_enable[1] | periph_enable[4]), RT_FIRST_CAN))
      else $error("first CAN page steered wrongly");
   AST_PWM_PAGE: assert property (
      cpu_req_valid && ce && cpu_req_addr[23:8] == `WIN_PWM |=>
      route == page($past(periph_enable[4]),
         $past(periph_enable[0] | periph_enable[1]), RT_PWM))
      else $error("PWM page steered wrongly");
   // Pin release lags the selection by one enabled edge
   AST_PINS_FREE: assert property (
      $stable(periph_enable) && $past(ce) |->
      first_can_pins_gpio == !periph_enable[0] &&
      second_can_pins_gpio == !periph_enable[1])
      else $error("CAN pin release does not follow the enables");
   AST_LOCKED: assert property (
      global_xbus_enable |=> $stable(periph_enable))
      else $error("selection changed while locked");
   AST_LOCK_STICKY: assert property (
      global_xbus_enable |=> global_xbus_enable)
      else $error("global enable cleared without reset");

   cover property (route_valid && route == RT_BLOCKED);
   cover property (route_valid && route == RT_FIRST_CAN);
   cover property (global_xbus_enable && !second_can_pins_gpio);
   cover property (!ce && cpu_req_valid);
endmodule // xbus_sel_monitor

bind xbus_peripheral_select_decode xbus_sel_monitor xbus_sel_monitor_i (
   .aclk(aclk), .aresetn(aresetn), .ce(ce), .cpu_req_valid(cpu_req_valid),
   .cpu_req_addr(cpu_req_addr), .route_valid(route_valid), .route(route),
   .periph_enable(periph_enable), .global_xbus_enable(global_xbus_enable),
   .first_can_pins_gpio(first_can_pins_gpio),
   .second_can_pins_gpio(second_can_pins_gpio));

// ==== tb/tb.sv ====
// Self-checking bench for the extension-bus select decoder
`timescale 1ns/1ps
`include "xbus_sel_cfg.svh"
module tb;
   import xbus_sel_pkg::*;
   logic        aclk, awready, wready, bvalid, arready, rvalid, rtv, g1, g2;
   logic        aresetn = 1'b0, ce = 1'b1, gen, cpu_v;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'h0;
   logic [1:0]  bresp, rresp;
   logic [23:0] cpu_a;
   logic [4:0]  sel;
   route_t      route;
   int          n_fail = 0, comparisons = 0;
   logic [23:0] addrs [10] = '{24'h00ef10, 24'h00ee20, 24'h00ed30,
      24'h00ecff, 24'h008000, 24'h00bfff, 24'h00c000, 24'h010000,
      24'h0103ff, 24'h010400};

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Windows moved apart so extension RAM and group never overlap
   xbus_peripheral_select_decode #(.EXT_RAM_BASE(32'h008000),
      .GRP_BASE(32'h010000)) xbus_peripheral_select_decode_i (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cpu_req_valid(cpu_v), .cpu_req_addr(cpu_a),
      .route_valid(rtv), .route(route), .periph_enable(sel),
      .global_xbus_enable(gen), .first_can_pins_gpio(g1),
      .second_can_pins_gpio(g2));
   cpu_access_model cpu_access_model_i (.aclk(aclk), .req_valid(cpu_v),
      .req_addr(cpu_a));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic hang();
      n_fail++;
      tally_and_finish();
   endtask

   // Write cycle; address and data are released each as it is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [3:0] st, input logic [1:0] er);
      int n;
      n = 0;
      awaddr  <= a;
      wdata   <= v;
      wstrb   <= st;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready && awvalid)
            awvalid <= 1'b0;
         if (wready && wvalid)
            wvalid <= 1'b0;
      end while (!bvalid && n < 40);
      if (!bvalid)
         hang();
      check(32'(bresp), 32'(er));
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ev,
                     input logic [1:0] er);
      int n;
      n = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready && arvalid)
            arvalid <= 1'b0;
      end while (!rvalid && n < 40);
      if (!rvalid)
         hang();
      check(rdata, ev);
      check(32'(rresp), 32'(er));
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   function automatic route_t pg(input logic on, input logic off,
                                 input route_t u);
      return on ? u : off ? RT_EXTERNAL : RT_BLOCKED;
   endfunction

   // Expected steering for a selection value and an access address
   function automatic route_t want(input logic [4:0] s, input logic [23:0] a);
      logic off;
      off = !(s[0] | s[1] | s[4]);
      case (a[23:8])
         `WIN_FIRST_CAN:  return pg(s[0], off, RT_FIRST_CAN);
         `WIN_SECOND_CAN: return pg(s[1], off, RT_SECOND_CAN);
         `WIN_GAP:        return pg(1'b0, off, RT_BLOCKED);
         `WIN_PWM:        return pg(s[4], off, RT_PWM);
         default:         ;
      endcase
      if (a inside {[24'h008000:24'h00bfff]})
         return s[2] ? RT_EXT_RAM : RT_EXTERNAL;
      if (a inside {[24'h010000:24'h0103ff]})
         return s[3] ? RT_GROUP : RT_EXTERNAL;
      return RT_EXTERNAL;
   endfunction

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      check(32'({gen, g2, g1, sel}), 32'({3'b010, `SEL_RESET}));
      rd(`OFS_PERIPH_SEL, 32'(`SEL_RESET), `RESP_OKAY);
      rd(`OFS_STATUS, 32'h4, `RESP_OKAY);
      $display("reset test done");
      // Every selection value against one address per extension page and the RAM and group window edges
      for (int s = 0; s < 32; s++) begin
         wr(`OFS_PERIPH_SEL, 32'(s), 4'h1, `RESP_OKAY);
         rd(`OFS_PERIPH_SEL, 32'(s), `RESP_OKAY);
         check(32'({sel, g2, g1}), 32'({5'(s), !s[1], !s[0]}));
         foreach (addrs[i]) begin
            cpu_access_model_i.access(addrs[i]);
            @(posedge aclk);
            check(32'({rtv, route}),
               32'({1'b1, want(5'(s), addrs[i])}));
         end
      end
      $display("selection sweep done");
      wr(`OFS_PERIPH_SEL, 32'h0, 4'h0, `RESP_OKAY);
      rd(`OFS_PERIPH_SEL, 32'h1f, `RESP_OKAY);
      wr(8'h0c, 32'h1, 4'hf, `RESP_DECERR);
      rd(8'h0c, 32'h0, `RESP_DECERR);
      $display("refusal test done");
      wr(`OFS_PERIPH_SEL, 32'h0a, 4'h1, `RESP_OKAY);
      wr(`OFS_SYS_CONFIG, 32'h1, 4'h1, `RESP_OKAY);
      wr(`OFS_PERIPH_SEL, 32'h15, 4'h1, `RESP_OKAY);
      rd(`OFS_PERIPH_SEL, 32'h0a, `RESP_OKAY);
      rd(`OFS_STATUS, 32'h3, `RESP_OKAY);
      cpu_access_model_i.access(24'h00ef10);
      @(posedge aclk);
      check(32'(route), 32'(RT_BLOCKED));
      $display("lock test done");
      // A low clock enable freezes steering: no pulse, route held
      ce <= 1'b0;
      cpu_access_model_i.access(24'h00ee20);
      @(posedge aclk);
      check(32'({rtv, route}), 32'({1'b0, RT_BLOCKED}));
      ce <= 1'b1;
      cpu_access_model_i.access(24'h00ee20);
      @(posedge aclk);
      check(32'({rtv, route}), 32'({1'b1, RT_SECOND_CAN}));
      $display("clock enable test done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      check(32'({gen, sel}), 32'({1'b0, `SEL_RESET}));
      $display("mid-run reset test done");
      tally_and_finish();
   end
endmodule // tb
